// >>> asrw_top.sv
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE_01: standby bit set keeps receiver idle-waiting and masks receiver irqs
// RULE_02: address-mark wakeup: msb 1 clears standby and sets rx full
// RULE_03: idle wakeup clears standby, sets neither quiet nor full flag
// RULE_04: quiet count start: 1 after stop bit, 0 after start bit
// RULE_05: rx full set on transfer; irq only with its enable
// RULE_06: quiet flag after 10 or 11 ones; irq only with enable
// RULE_07: overrun keeps old character, drops the new one
// RULE_08: each fault flag raises error irq only with own enable
// RULE_09: noise in start, data or stop sample sets noise flag
// RULE_10: zero at stop bit position sets framing fault flag
// RULE_11: parity mismatch against odd/even select sets parity flag
// RULE_12: wait mode keeps running, blocks bus, irqs still wake
// RULE_13: stop mode halts, keeps registers; interrupted transfer invalid
// RULE_14: in break with clear-enable 0 accesses leave flags alone
// RULE_15: in break with clear-enable 1 clears stick after break
// RULE_16: enabled module owns tx pin as output, rx pin as input
// RULE_17: loop mode feeds receiver from transmitter output
// RULE_18: enable bit runs baud; clearing sets tx empty and done
// RULE_19: inversion reverses every transmitted level
// RULE_20: length select 1 gives 9-bit, 0 gives 8-bit characters
// RULE_21: parity in msb, odd when select 1, even when 0
// RULE_22: reset clears all line_format_control bits
// RULE_23: software clears rx full by status read then data read
module asrw_top
  import asrw_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_pin_i,
  input wire logic tx_line_i,
  output logic tx_pin_o,
  output logic tx_pin_oe_o,
  output logic rx_pin_oe_o,
  output logic rx_irq_o,
  output logic err_irq_o,
  output logic tx_irq_o,
  output logic wake_req_o
);
  // ==========================================================
  // registers
  logic [7:0] lfc, c2, c3, st, dr, sys;
  logic r8;
  logic rf_armed;
  logic rx_s1, rx_s2;
  logic [15:0] pre;
  logic rt_tick;
  logic [3:0] rt;
  logic [3:0] bitn;
  logic [8:0] shf;
  logic [2:0] smp;
  logic noise_acc;
  logic [3:0] ones;
  logic idle_done;
  logic ack;
  typedef enum {ASRW_IDLE, ASRW_START, ASRW_DATA, ASRW_STOP} asrw_st_t;
  asrw_st_t rxs;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction
  function automatic logic noisy3(input logic [2:0] s);
    noisy3 = ~((s == 3'h0) | (s == 3'h7));
  endfunction

  // ==========================================================
  // bus decode
  logic [3:0] idx;
  logic acc, wr, rd, brk, frz, stopm, run, rx_in, rx_on;
  assign idx = wb_adr_i[5:2];
  // bus blocked in wait and stop mode; sys stays open so they can be left
  assign acc = wb_cyc_i & wb_stb_i & ~ack
               & (~(sys[ASRW_B_WAITM] | sys[ASRW_B_STOPM])
                  | (idx == ASRW_OFF_SYS));
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  assign brk = sys[ASRW_B_BRK];
  // RULE_14: break without clear-enable freezes flags
  assign frz = brk & ~sys[ASRW_B_HALT_CLEAR_ENABLE];
  // RULE_13: stop halts all shifting, registers retained
  assign stopm = sys[ASRW_B_STOPM];
  // RULE_18: enable gates the baud generator
  assign run = lfc[ASRW_B_EN] & ~stopm;
  // RULE_17: loop takes transmitter output instead of pin
  assign rx_in = lfc[ASRW_B_LOOP] ? tx_line_i : rx_s2;
  assign rx_on = run & c2[ASRW_B_RE];

  // rx pin synchroniser, second stage only is read
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= rx_pin_i;
      rx_s2 <= rx_s1;
    end
  end

  // wishbone ack, one cycle, dropped after each answer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack <= 1'b0;
      wb_ack_o <= 1'b0;
    end else begin
      ack <= acc;
      wb_ack_o <= acc;
    end
  end

  // read mux; unmapped reads answer zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      unique case (idx)
        ASRW_OFF_LFC: wb_dat_o <= {24'h00_0000, lfc};
        ASRW_OFF_C2: wb_dat_o <= {24'h00_0000, c2};
        ASRW_OFF_C3: wb_dat_o <= {24'h00_0000, r8, c3[6:0]};
        ASRW_OFF_ST: wb_dat_o <= {24'h00_0000, st};
        ASRW_OFF_DR: wb_dat_o <= {24'h00_0000, dr};
        ASRW_OFF_SYS: wb_dat_o <= {24'h00_0000, sys};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // RULE_22: reset clears line_format_control
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lfc <= ASRW_RST_LFC;
    end else if (wr && idx == ASRW_OFF_LFC) begin
      lfc <= wb_dat_i[7:0];
    end
  end

  // third control and system control registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      c3 <= 8'h00;
      sys <= 8'h00;
    end else begin
      if (wr && idx == ASRW_OFF_C3) begin
        c3 <= wb_dat_i[7:0];
      end
      // same one-cycle answer as every other register
      if (wr && idx == ASRW_OFF_SYS) begin
        sys <= {4'h0, wb_dat_i[3:0]};
      end
    end
  end

  // ==========================================================
  // rt tick: 16x baud
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !run) begin
      pre <= 16'h0000;
      rt_tick <= 1'b0;
    end else if (pre == ASRW_RT_DIV - 16'h0001) begin
      pre <= 16'h0000;
      rt_tick <= 1'b1;
    end else begin
      pre <= pre + 16'h0001;
      rt_tick <= 1'b0;
    end
  end

  // frame shape
  logic [3:0] nbits;
  // RULE_20: nine or eight character bits
  assign nbits = lfc[ASRW_B_M] ? 4'h9 : 4'h8;
  logic done, stop_ok, stop_noise, par_bad, msb;
  logic [2:0] smp_n;
  assign smp_n = {smp[1:0], rx_in};
  assign msb = lfc[ASRW_B_M] ? shf[8] : shf[7];

  // receiver state machine
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !rx_on) begin
      rxs <= ASRW_IDLE;
      rt <= 4'h0;
      bitn <= 4'h0;
      shf <= 9'h000;
      smp <= 3'h7;
      noise_acc <= 1'b0;
    end else if (rt_tick) begin
      rt <= rt + 4'h1;
      if (rt >= ASRW_RT_MID - 4'h1 && rt <= ASRW_RT_MID + 4'h1) begin
        smp <= smp_n;
      end
      unique case (rxs)
        ASRW_IDLE: begin
          // rt keeps running so idle bit times are counted
          noise_acc <= 1'b0;
          if (!rx_in) begin
            rxs <= ASRW_START;
            rt <= 4'h1;
          end
        end
        ASRW_START: begin
          if (rt == ASRW_RT_MID + 4'h1) begin
            // RULE_09: start sample noise
            noise_acc <= noisy3(smp_n);
            if (maj3(smp_n)) begin
              rxs <= ASRW_IDLE;
            end
          end
          if (rt == ASRW_RT_LAST) begin
            rxs <= ASRW_DATA;
            bitn <= 4'h0;
          end
        end
        ASRW_DATA: begin
          if (rt == ASRW_RT_MID + 4'h1) begin
            noise_acc <= noise_acc | noisy3(smp_n);
            shf <= lfc[ASRW_B_M] ? {maj3(smp_n), shf[8:1]}
                                 : {1'b0, maj3(smp_n), shf[7:1]};
          end
          if (rt == ASRW_RT_LAST) begin
            bitn <= bitn + 4'h1;
            if (bitn == nbits - 4'h1) begin
              rxs <= ASRW_STOP;
            end
          end
        end
        ASRW_STOP: begin
          if (rt == ASRW_RT_MID + 4'h1) begin
            rxs <= ASRW_IDLE;
          end
        end
      endcase
    end
  end

  assign done = rx_on & rt_tick & (rxs == ASRW_STOP)
                & (rt == ASRW_RT_MID + 4'h1);
  assign stop_ok = maj3(smp_n);
  assign stop_noise = noisy3(smp_n);
  // RULE_21: parity over all character bits, odd select flips
  assign par_bad = lfc[ASRW_B_PEN] &
    ((lfc[ASRW_B_M] ? ^shf[8:0] : ^shf[7:0]) != lfc[ASRW_B_PTY]);

  // RULE_04: ones counted in bit times after start or after stop
  logic bit_end, cnt_ok;
  assign bit_end = rx_on & rt_tick & (rt == ASRW_RT_LAST);
  assign cnt_ok = lfc[ASRW_B_QUIET_COUNT_START_SELECT] ? (rxs == ASRW_IDLE)
                                   : (rxs != ASRW_START);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !rx_on) begin
      ones <= 4'h0;
      idle_done <= 1'b0;
    end else if (!rx_in && rxs == ASRW_IDLE) begin
      ones <= 4'h0;
      idle_done <= 1'b0;
    end else if (rxs == ASRW_DATA && rt_tick && rt == ASRW_RT_MID + 4'h1
                 && !maj3(smp_n)) begin
      ones <= 4'h0;
    end else if (bit_end && cnt_ok && !idle_done
                 && (rxs == ASRW_IDLE || rx_in)) begin
      ones <= ones + 4'h1;
    end else if (ones == nbits + 4'h2) begin
      // RULE_06: 10 or 11 ones make an idle character
      idle_done <= 1'b1;
      ones <= 4'h0;
    end
  end
  logic idle_ev;
  assign idle_ev = rx_on & (ones == nbits + 4'h2) & ~idle_done;

  // ==========================================================
  // control 2, standby bit
  logic wake;
  // RULE_02: address mark, RULE_03: idle character
  assign wake = c2[ASRW_B_RWU] & (lfc[ASRW_B_WAKE] ? (done & msb)
                                                  : idle_ev);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      c2 <= 8'h00;
    end else if (wake) begin
      c2[ASRW_B_RWU] <= 1'b0;
    end else if (wr && idx == ASRW_OFF_C2) begin
      c2 <= wb_dat_i[7:0];
      // enables writable only while module is on
      if (!lfc[ASRW_B_EN]) begin
        c2[ASRW_B_RE] <= c2[ASRW_B_RE];
        c2[ASRW_B_TE] <= c2[ASRW_B_TE];
      end
    end
  end

  // ==========================================================
  // status flags; hardware set wins over software clear
  logic sb, take, clr_ok, st_rd, dr_rd, dr_wr;
  assign sb = c2[ASRW_B_RWU];
  // RULE_01: standby discards ordinary characters
  assign take = done & (~sb | (lfc[ASRW_B_WAKE] & msb));
  // RULE_15: break with clear-enable allows clears
  assign clr_ok = ~frz;
  assign st_rd = rd & (idx == ASRW_OFF_ST);
  assign dr_rd = rd & (idx == ASRW_OFF_DR);
  assign dr_wr = wr & (idx == ASRW_OFF_DR);

  // armed by status read; arming survives a frozen break
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rf_armed <= 1'b0;
    end else if (st_rd && clr_ok) begin
      rf_armed <= |st[5:0];
    end else if (dr_rd && clr_ok) begin
      rf_armed <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= ASRW_RST_ST;
      dr <= 8'h00;
      r8 <= 1'b0;
    end else begin
      // RULE_23: status read then data read clears receiver flags
      if (dr_rd && clr_ok && rf_armed) begin
        st[5:0] <= 6'h00;
      end
      if (dr_wr && clr_ok && st[ASRW_B_TE_F]) begin
        st[ASRW_B_TE_F] <= 1'b0;
        st[ASRW_B_TC] <= 1'b0;
      end
      // RULE_18: disabled module reports transmitter empty and done
      if (!lfc[ASRW_B_EN]) begin
        st[ASRW_B_TE_F] <= 1'b1;
        st[ASRW_B_TC] <= 1'b1;
      end
      // RULE_06: idle flag, not on a waking idle character
      if (idle_ev && !sb) begin
        st[ASRW_B_IDLE] <= 1'b1;
      end
      if (take) begin
        if (st[ASRW_B_RF] && !(dr_rd && clr_ok && rf_armed)) begin
          // RULE_07: overrun keeps the old character
          st[ASRW_B_OR] <= 1'b1;
        end else begin
          // RULE_05: transfer sets rx full
          st[ASRW_B_RF] <= 1'b1;
          dr <= shf[7:0];
          r8 <= lfc[ASRW_B_M] ? shf[8] : shf[7];
          // RULE_10: zero at stop position
          st[ASRW_B_FF] <= ~stop_ok;
          // RULE_09: noise in any sample group
          st[ASRW_B_NF] <= noise_acc | stop_noise;
          // RULE_11: parity mismatch
          st[ASRW_B_PF] <= par_bad;
        end
      end
    end
  end

  // ==========================================================
  // interrupt requests and pins, all registered
  logic rxq, erq, txq;
  // RULE_01: standby masks receiver requests
  // RULE_05: rx full gated by its enable
  assign rxq = ~sb & ((st[ASRW_B_RF] & c2[ASRW_B_RIE])
                      | (st[ASRW_B_IDLE] & c2[ASRW_B_QUIET_IRQ_ENABLE]));
  // RULE_08: each fault with its own enable
  assign erq = (st[ASRW_B_OR] & c3[ASRW_B_OVERRUN_IRQ_ENABLE])
             | (st[ASRW_B_NF] & c3[ASRW_B_NOISE_IRQ_ENABLE])
             | (st[ASRW_B_FF] & c3[ASRW_B_FRAMING_IRQ_ENABLE])
             | (st[ASRW_B_PF] & c3[ASRW_B_PARITY_IRQ_ENABLE]);
  // RULE_18: transmitter requests only while enabled
  assign txq = lfc[ASRW_B_EN] & ((st[ASRW_B_TE_F] & c2[ASRW_B_TIE])
                                 | (st[ASRW_B_TC] & c2[ASRW_B_TCIE]));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_irq_o <= 1'b0;
      err_irq_o <= 1'b0;
      tx_irq_o <= 1'b0;
      wake_req_o <= 1'b0;
      tx_pin_o <= 1'b1;
      tx_pin_oe_o <= 1'b0;
      rx_pin_oe_o <= 1'b0;
    end else begin
      rx_irq_o <= rxq;
      err_irq_o <= erq;
      tx_irq_o <= txq;
      // RULE_12: any enabled request raises wake_req_o in wait mode
      wake_req_o <= sys[ASRW_B_WAITM] & (rxq | erq | txq);
      // RULE_19: inversion on every level incl. idle
      tx_pin_o <= tx_line_i ^ lfc[ASRW_B_INV];
      // RULE_16: enabled module owns pin directions
      tx_pin_oe_o <= lfc[ASRW_B_EN];
      rx_pin_oe_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> asrw_pkg.sv
package asrw_pkg;
  // ==========================================================
  // register map (word addresses, byte offset = 4 * index)
  localparam logic [3:0] ASRW_OFF_LFC = 4'h0;  // line_format_control
  localparam logic [3:0] ASRW_OFF_C2 = 4'h1;   // second_control_reg
  localparam logic [3:0] ASRW_OFF_C3 = 4'h2;   // third_control_reg
  localparam logic [3:0] ASRW_OFF_ST = 4'h3;   // first_status_reg
  localparam logic [3:0] ASRW_OFF_DR = 4'h4;   // char_data_reg
  localparam logic [3:0] ASRW_OFF_SYS = 4'h5;  // module-level controls
  // ==========================================================
  // line_format_control field positions
  localparam int ASRW_B_PTY = 0;
  localparam int ASRW_B_PEN = 1;
  localparam int ASRW_B_QUIET_COUNT_START_SELECT = 2;
  localparam int ASRW_B_WAKE = 3;
  localparam int ASRW_B_M = 4;
  localparam int ASRW_B_INV = 5;
  localparam int ASRW_B_EN = 6;
  localparam int ASRW_B_LOOP = 7;
  // second_control_reg fields
  localparam int ASRW_B_RWU = 1;
  localparam int ASRW_B_RE = 2;
  localparam int ASRW_B_TE = 3;
  localparam int ASRW_B_QUIET_IRQ_ENABLE = 4;
  localparam int ASRW_B_RIE = 5;
  localparam int ASRW_B_TCIE = 6;
  localparam int ASRW_B_TIE = 7;
  // third_control_reg fields
  localparam int ASRW_B_PARITY_IRQ_ENABLE = 0;
  localparam int ASRW_B_FRAMING_IRQ_ENABLE = 1;
  localparam int ASRW_B_NOISE_IRQ_ENABLE = 2;
  localparam int ASRW_B_OVERRUN_IRQ_ENABLE = 3;
  // first_status_reg fields
  localparam int ASRW_B_PF = 0;
  localparam int ASRW_B_FF = 1;
  localparam int ASRW_B_NF = 2;
  localparam int ASRW_B_OR = 3;
  localparam int ASRW_B_IDLE = 4;
  localparam int ASRW_B_RF = 5;
  localparam int ASRW_B_TC = 6;
  localparam int ASRW_B_TE_F = 7;
  // sys register fields
  localparam int ASRW_B_HALT_CLEAR_ENABLE = 0;
  localparam int ASRW_B_BRK = 1;
  localparam int ASRW_B_WAITM = 2;
  localparam int ASRW_B_STOPM = 3;
  // ==========================================================
  // reset values and timing
  localparam logic [7:0] ASRW_RST_LFC = 8'h00;
  localparam logic [7:0] ASRW_RST_ST = 8'hC0;
  localparam int ASRW_CLK_HZ = 25000000;
  localparam int ASRW_BAUD = 115200;
  localparam logic [15:0] ASRW_RT_DIV =
    16'((ASRW_CLK_HZ + 8 * ASRW_BAUD) / (16 * ASRW_BAUD));
  localparam logic [3:0] ASRW_RT_MID = 4'h8;
  localparam logic [3:0] ASRW_RT_LAST = 4'hF;
endpackage

// >>> asrw_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// port checker
module asrw_asserts
  import asrw_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_pin_i,
  input wire logic tx_line_i,
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe_o,
  input wire logic rx_pin_oe_o,
  input wire logic rx_irq_o,
  input wire logic err_irq_o,
  input wire logic tx_irq_o,
  input wire logic wake_req_o
);
  logic en, inv, waitm, stopm, wr_ok;
  logic [1:0] rxie;
  logic [3:0] errie, idx;
  assign idx = wb_adr_i[5:2];
  assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
  // shadow copies move at the ack edge, so checks skip two cycles
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {en, inv, waitm, stopm, rxie, errie} <= '0;
    end else if (wr_ok && idx == ASRW_OFF_LFC) begin
      en <= wb_dat_i[ASRW_B_EN];
      inv <= wb_dat_i[ASRW_B_INV];
    end else if (wr_ok && idx == ASRW_OFF_C2) begin
      rxie <= {wb_dat_i[ASRW_B_RIE], wb_dat_i[ASRW_B_QUIET_IRQ_ENABLE]};
    end else if (wr_ok && idx == ASRW_OFF_C3) begin
      errie <= wb_dat_i[3:0];
    end else if (wr_ok && idx == ASRW_OFF_SYS) begin
      waitm <= wb_dat_i[ASRW_B_WAITM];
      stopm <= wb_dat_i[ASRW_B_STOPM];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ====
  // steps
  sequence s_settled;
    !wb_ack_o && !$past(wb_ack_o) && !$past(sys_rst_i);
  endsequence
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o
      && (!(waitm || stopm) || idx == ASRW_OFF_SYS);
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // ====
  // assertions
  AST_ACK_WALK: assert property (s_take |=> s_answer)
    else $error("ack not one cycle after request");
  AST_LP_REFUSE: assert property ((waitm || stopm) && wb_cyc_i
    && wb_stb_i && idx != ASRW_OFF_SYS |-> !wb_ack_o)
    else $error("access acked in low power");
  AST_TX_INV: assert property (
    s_settled |-> tx_pin_o == ($past(tx_line_i) ^ inv))
    else $error("tx pin polarity wrong");
  AST_TX_OWN: assert property (s_settled |-> tx_pin_oe_o == en)
    else $error("tx enable not module enable");
  AST_RX_IN: assert property (rx_pin_oe_o == 1'b0)
    else $error("rx pin driven");
  AST_TX_IRQ_OFF: assert property (s_settled ##0 !en |-> !tx_irq_o)
    else $error("tx irq while disabled");
  AST_RX_MASK: assert property (
    s_settled ##0 rxie == 2'b00 |-> !rx_irq_o)
    else $error("rx irq while masked");
  AST_ERR_MASK: assert property (
    s_settled ##0 errie == 4'h0 |-> !err_irq_o)
    else $error("error irq while masked");
  AST_WAKE_WAIT: assert property (
    s_settled ##0 !waitm |-> !wake_req_o)
    else $error("wake request outside wait");
endmodule
bind asrw_top asrw_asserts i_asrw_asserts (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_pin_i(rx_pin_i), .tx_line_i(tx_line_i),
  .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o),
  .rx_pin_oe_o(rx_pin_oe_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o),
  .tx_irq_o(tx_irq_o), .wake_req_o(wake_req_o)
);
`default_nettype wire

// >>> asrw_line_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// remote transmitter on the receive pin
module asrw_line_model
  import asrw_pkg::*;
#(
  parameter int BIT_CLKS = 224
) (
  input wire logic clk_i,
  output logic line_o
);
  // line rests high between frames
  initial line_o = 1'b1;
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line_o <= bits[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> asrw_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin \
  samples_checked++; \
  if ((e) !== (s)) begin \
    miscompares++; \
    $display("Error %s expected %h seen %h", nm, e, s); \
  end \
end
module asrw_top_tb
  import asrw_pkg::*;
;
  localparam int BITC = 16 * int'(ASRW_RT_DIV);
  logic clk_i, sys_rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, g;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, seed;
  logic [3:0] wb_sel_i;
  logic rx_pin_i, tx_line_i, tx_pin_o, tx_pin_oe_o, rx_pin_oe_o;
  logic rx_irq_o, err_irq_o, tx_irq_o, wake_req_o;
  logic [7:0] v;
  logic [7:0] q[$];
  int miscompares, samples_checked, m_or;
  asrw_top i_asrw_top (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_pin_i(rx_pin_i), .tx_line_i(tx_line_i),
    .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o),
    .rx_pin_oe_o(rx_pin_oe_o), .rx_irq_o(rx_irq_o),
    .err_irq_o(err_irq_o), .tx_irq_o(tx_irq_o), .wake_req_o(wake_req_o)
  );
  asrw_line_model #(.BIT_CLKS(BITC)) i_asrw_line_model (
    .clk_i(clk_i), .line_o(rx_pin_i)
  );
  // ====
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  // single classic cycle; lim 0 waits for ack, else a refused probe
  task automatic bus(input logic [3:0] a, input logic we,
      input logic [7:0] wd, input int lim, output logic [7:0] rd,
      output logic got);
    int n;
    n = 0;
    wb_adr_i <= {26'h0, a, 2'b00};
    wb_we_i <= we;
    wb_dat_i <= {24'h0, wd};
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && (lim == 0 || n < lim));
    got = (wb_ack_o === 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus(a, 1'b0, 8'h00, 0, d, g);
    `CHK("ack", 1'b1, g)
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(a, 1'b1, d, 0, r, g);
    `CHK("ack", 1'b1, g)
  endtask
  // model: first unread character kept, later ones only flag overrun
  task automatic rx(input logic [7:0] d, input logic stop, input logic take);
    i_asrw_line_model.send({2'b11, stop, d, 1'b0}, 10);
    if (take && q.size() > 0) m_or = 1;
    else if (take) q.push_back(d);
  endtask
  task automatic drain(input logic [7:0] extra);
    logic [7:0] ex;
    ex = extra | (q.size() > 0 ? 8'h20 : 8'h00) | (m_or != 0 ? 8'h08 : 8'h00);
    rd(ASRW_OFF_ST, v);
    `CHK("status", ex, v & 8'h2f)
    rd(ASRW_OFF_DR, v);
    if (q.size() > 0) `CHK("data", q[0], v)
    q.delete();
    m_or = 0;
    rd(ASRW_OFF_ST, v);
    `CHK("cleared", 8'h00, v & 8'h2f)
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ====
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    report_and_stop();
  end
  // ====
  // main sequence
  initial begin
    {wb_adr_i, wb_dat_i, wb_sel_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
    sys_rst_i = 1'b1;
    tx_line_i = 1'b1;
    seed = 32'd5034;
    m_or = 0;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ASRW_OFF_LFC, v);
    `CHK("format", 8'h00, v)
    rd(ASRW_OFF_ST, v);
    `CHK("status", 8'hc0, v)
    rd(4'h6, v);
    `CHK("unmapped", 8'h00, v)
    wr(ASRW_OFF_LFC, 8'h40);
    wr(ASRW_OFF_C2, 8'h2c);
    // random transmit levels, inversion switched on halfway
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      if (i == 4) wr(ASRW_OFF_LFC, 8'h60);
      tx_line_i <= seed[0];
      repeat (2) @(posedge clk_i);
      `CHK("tx_pin", seed[0] ^ (i >= 4), tx_pin_o)
    end
    `CHK("tx_oe", 1'b1, tx_pin_oe_o)
    tx_line_i <= 1'b1;
    wr(ASRW_OFF_LFC, 8'h40);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      rx(seed[7:0], 1'b1, 1'b1);
      `CHK("rx_irq", 1'b1, rx_irq_o)
      drain(8'h00);
    end
    // overrun then framing fault, each behind its own enable
    wr(ASRW_OFF_C3, 8'h08);
    rx(8'ha5, 1'b1, 1'b1);
    rx(8'h3c, 1'b1, 1'b1);
    `CHK("err_irq", 1'b1, err_irq_o)
    wr(ASRW_OFF_C3, 8'h07);
    `CHK("err_irq", 1'b0, err_irq_o)
    drain(8'h00);
    rx(8'h55, 1'b0, 1'b1);
    `CHK("err_irq", 1'b1, err_irq_o)
    drain(8'h02);
    // even and odd parity, good and bad parity bit
    for (int i = 0; i < 4; i++) begin
      wr(ASRW_OFF_LFC, 8'h42 | {7'h00, i[1]});
      seed = xs(seed);
      rx({^seed[6:0] ^ i[1] ^ i[0], seed[6:0]}, 1'b1, 1'b1);
      drain({7'h00, i[0]});
    end
    wr(ASRW_OFF_LFC, 8'h48);
    wr(ASRW_OFF_C2, 8'h2e);
    rx(8'h12, 1'b1, 1'b0);
    `CHK("rx_irq", 1'b0, rx_irq_o)
    rd(ASRW_OFF_C2, v);
    `CHK("standby", 1'b1, v[ASRW_B_RWU])
    rx(8'h92, 1'b1, 1'b1);
    rd(ASRW_OFF_C2, v);
    `CHK("standby", 1'b0, v[ASRW_B_RWU])
    drain(8'h00);
    wr(ASRW_OFF_LFC, 8'h40);
    wr(ASRW_OFF_C2, 8'h2e);
    repeat (13 * BITC) @(posedge clk_i);
    rd(ASRW_OFF_C2, v);
    `CHK("standby", 1'b0, v[ASRW_B_RWU])
    rd(ASRW_OFF_ST, v);
    `CHK("full", 1'b0, v[ASRW_B_RF])
    `CHK("quiet", 1'b0, v[ASRW_B_IDLE])
    // quiet line flag raises the receiver request through its own enable
    wr(ASRW_OFF_C2, 8'h1c);
    rx(8'h81, 1'b1, 1'b1);
    repeat (11 * BITC) @(posedge clk_i);
    `CHK("quiet_irq", 1'b1, rx_irq_o)
    rd(ASRW_OFF_ST, v);
    `CHK("quiet", 1'b1, v[ASRW_B_IDLE])
    drain(8'h00);
    wr(ASRW_OFF_C2, 8'h2c);
    // wait mode: bus refused, receiver still raises a wake request
    wr(ASRW_OFF_SYS, 8'h04);
    bus(ASRW_OFF_ST, 1'b0, 8'h00, 20, v, g);
    `CHK("refused", 1'b0, g)
    rx(8'h5a, 1'b1, 1'b1);
    `CHK("wake", 1'b1, wake_req_o)
    wr(ASRW_OFF_SYS, 8'h00);
    drain(8'h00);
    for (int i = 0; i < 2; i++) begin
      rx(8'hc3, 1'b1, 1'b1);
      rd(ASRW_OFF_ST, v);
      wr(ASRW_OFF_SYS, {6'h00, 1'b1, i[0]});
      rd(ASRW_OFF_DR, v);
      rd(ASRW_OFF_ST, v);
      `CHK("held", !i[0], v[ASRW_B_RF])
      wr(ASRW_OFF_SYS, 8'h00);
      rd(ASRW_OFF_DR, v);
      rd(ASRW_OFF_ST, v);
      `CHK("after", 1'b0, v[ASRW_B_RF])
      q.delete();
    end
    // nine-bit character, bit 8 read back through the third control
    wr(ASRW_OFF_LFC, 8'h50);
    i_asrw_line_model.send({2'b11, 9'h125, 1'b0}, 11);
    q.push_back(8'h25);
    rd(ASRW_OFF_C3, v);
    `CHK("bit8", 1'b1, v[7])
    drain(8'h00);
    wr(ASRW_OFF_C2, 8'h4c);
    wr(ASRW_OFF_SYS, 8'h08);
    wr(ASRW_OFF_SYS, 8'h00);
    rd(ASRW_OFF_C2, v);
    `CHK("kept", 8'h4c, v)
    // loop mode: a held-low transmitter arrives as a break character
    wr(ASRW_OFF_LFC, 8'hc0);
    tx_line_i <= 1'b0;
    repeat (10 * BITC) @(posedge clk_i);
    tx_line_i <= 1'b1;
    q.push_back(8'h00);
    drain(8'h02);
    wr(ASRW_OFF_LFC, 8'h00);
    `CHK("tx_irq", 1'b0, tx_irq_o)
    rd(ASRW_OFF_ST, v);
    `CHK("tx_flags", 2'b11, v[7:6])
    `CHK("tx_oe", 1'b0, tx_pin_oe_o)
    report_and_stop();
  end
endmodule
`default_nettype wire
